// [shared/dwps_pkg.sv]
package dwps_pkg;
  // register map, byte addresses on a 5-bit bus address
  localparam int AXI_AW = 5;
  localparam logic [AXI_AW-1:0] OFF_MODE0 = 5'h00;
  localparam logic [AXI_AW-1:0] OFF_MODE2 = 5'h04;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 5'h08;
  localparam logic [AXI_AW-1:0] OFF_WDATA = 5'h0C;
  localparam logic [AXI_AW-1:0] OFF_SRCNT = 5'h10;
  // mode 0 burst field
  localparam int MODE0_BL_LSB = 0;
  localparam logic [1:0] MODE0_BL_RST = 2'h0;
  localparam logic [1:0] BL_MODE_8 = 2'h0;
  localparam logic [1:0] BL_MODE_OTF = 2'h1;
  localparam logic [1:0] BL_MODE_BC4 = 2'h2;
  // mode 2 self-refresh fields
  localparam int MODE2_ASR_BIT = 6;
  localparam int MODE2_SRT_BIT = 7;
  localparam logic MODE2_ASR_RST = 1'b0;
  localparam logic MODE2_SRT_RST = 1'b0;
  // status layout
  localparam int STAT_ERR_LSB = 16;
  localparam int ERR_W = 3;
  localparam int ERR_CLOSED = 0;
  localparam int ERR_SRE = 1;
  localparam int ERR_OVR = 2;
  // beats per burst
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  // command code {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WL_CK_DEF = 5;
  localparam int TREFI_NORM_NS = 7800;
  localparam int TREFI_EXT_NS = 3900;
  localparam int TREFI_NORM_CYC = TREFI_NORM_NS / CLK_PERIOD_NS;
  localparam int TREFI_EXT_CYC = TREFI_EXT_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] RELOAD_NORM = TMR_W'(TREFI_NORM_CYC - 1);
  localparam logic [TMR_W-1:0] RELOAD_EXT = TMR_W'(TREFI_EXT_CYC - 1);
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_SREF = 2'b10
  } dwps_dev_t;
endpackage

// [hdl/dwps_sync.sv]
`timescale 1ns/1ps
module dwps_sync
  import dwps_pkg::*;
#(
  parameter int W = 8
)
(
  // system
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // raw pins
  input wire logic [W-1:0] d,
  // synchronised level and edges
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dwps_sync_st_t;

  dwps_sync_st_t r;
  dwps_sync_st_t n;

  always_comb
  begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else if (ce)
      r <= n;
  end

  // s1 feeds only s2; edges look at s2 against s3
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign q[i] = r.s2[i];
    assign rise[i] = r.s2[i] & ~r.s3[i];
    assign fall[i] = ~r.s2[i] & r.s3[i];
  end
endmodule

// [hdl/dwps_dev.sv]
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module dwps_dev
  import dwps_pkg::*;
#(
  parameter int DQW = 16,
  parameter int WL = WL_CK_DEF
)
(
  // system
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // memory pins
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic a12,
  input wire logic [2:0] ba,
  input wire logic odt,
  input wire logic dqs_t,
  input wire logic [DQW-1:0] dq,
  // temperature sensor
  input wire logic hot,
  // captured write data
  output logic [DQW-1:0] wr_data,
  output logic wr_valid,
  // device state
  output logic in_sr,
  output logic dll_on,
  output logic dll_rst,
  output logic int_ref,
  // axi4-lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = DQW + 14;
  // ck rises a write must stay clear of the previous one; latency fits 15 slots
  localparam logic [1:0] CCD_LEFT = 2'h3;

  typedef struct packed {
    dwps_dev_t st;
    logic [1:0] bl_mode;
    logic asr;
    logic srt;
    logic [7:0] bank_open;
    logic cke_q;
    logic dll_on;
    logic dll_rst;
    logic iref;
    logic [15:0] iref_cnt;
    logic [TMR_W-1:0] iref_tmr;
    logic [3:0] rem;
    logic [14:0][3:0] lat;
    logic [1:0] ccd;
    logic rd_bc4;
    logic [ERR_W-1:0] err;
    logic [DQW-1:0] wdata;
    logic wvalid;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dwps_dev_st_t;

  dwps_dev_st_t r;
  dwps_dev_st_t n;

  logic [PW-1:0] ps;
  logic [PW-1:0] pr;
  logic [PW-1:0] pf;
  logic [DQW-1:0] dq_s;
  logic [2:0] ba_s;
  logic [2:0] cmd;
  logic a10_s, a12_s, cs_n_s, ck_rise, cke_s, odt_s, dqs_edge, hot_s;
  logic cmd_go, sre_cmd, srx, wr_go, pre_go, busy, take, add, ext;
  logic aw_hs, w_hs, ar_hs, wr_fire;
  logic [3:0] blen;
  logic [TMR_W-1:0] reload;
  logic [AXI_AW-1:0] awa_w;
  logic [AXI_AW-1:0] ara_w;

  // every pin crosses two flops before the decode looks at it
  dwps_sync #(.W(PW)) u_dwps_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d({hot, dqs_t, odt, cke, ck, cs_n, ras_n, cas_n, we_n, a12, a10, ba, dq}),
    .q(ps),
    .rise(pr),
    .fall(pf)
  );

  assign dq_s = ps[DQW-1:0];
  assign ba_s = ps[DQW+2:DQW];
  assign a10_s = ps[DQW+3];
  assign a12_s = ps[DQW+4];
  assign cmd = ps[DQW+7:DQW+5];
  assign cs_n_s = ps[DQW+8];
  assign ck_rise = pr[DQW+9];
  assign cke_s = ps[DQW+10];
  assign odt_s = ps[DQW+11];
  assign dqs_edge = pr[DQW+12] | pf[DQW+12];
  assign hot_s = ps[DQW+13];

  // command decode on each ck rising edge
  assign cmd_go = ck_rise && r.st == DEV_IDLE && !cs_n_s && cke_s && r.cke_q;
  assign sre_cmd = ck_rise && r.st == DEV_IDLE && !cs_n_s && r.cke_q && !cke_s
    && cmd == CMD_REF;
  assign srx = ck_rise && r.st == DEV_SREF && cke_s;
  assign wr_go = cmd_go && cmd == CMD_WR;
  assign pre_go = cmd_go && cmd == CMD_PRE;
  assign busy = r.rem != 4'h0 || r.lat != '0;
  assign blen = (r.bl_mode == BL_MODE_BC4 || (r.bl_mode == BL_MODE_OTF && !a12_s))
    ? BEATS_BC4 : BEATS_BL8;
  assign take = dqs_edge && r.rem != 4'h0 && r.st == DEV_IDLE;
  assign add = ck_rise && r.lat[0] != 4'h0;
  assign ext = r.asr ? hot_s : r.srt;
  assign reload = ext ? RELOAD_EXT : RELOAD_NORM;

  assign s_axi_awready = ce && !r.aw_got && !r.bvalid;
  assign s_axi_wready = ce && !r.w_got && !r.bvalid;
  assign s_axi_arready = ce && !r.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
  assign awa_w = {r.awa[AXI_AW-1:2], 2'b00};
  assign ara_w = {s_axi_araddr[AXI_AW-1:2], 2'b00};

  always_comb
  begin
    n = r;
    n.wvalid = 1'b0;
    n.dll_rst = 1'b0;
    n.iref = 1'b0;
    // bus side first so that hardware error sets below win over a clear
    if (aw_hs)
    begin
      n.aw_got = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (w_hs)
    begin
      n.w_got = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (wr_fire)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (awa_w)
        OFF_MODE0:
          if (r.ws[0])
            n.bl_mode = r.wd[MODE0_BL_LSB +: 2];
        OFF_MODE2:
          if (r.ws[0])
          begin
            n.asr = r.wd[MODE2_ASR_BIT];
            n.srt = r.wd[MODE2_SRT_BIT];
          end
        OFF_STATUS:
          if (r.ws[2])
            n.err = r.err & ~r.wd[STAT_ERR_LSB +: ERR_W];
        OFF_WDATA, OFF_SRCNT:
          n.bresp = RESP_OKAY;
        default:
          n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (ar_hs)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (ara_w)
        OFF_MODE0:
          n.rdata = {30'h0000_0000, r.bl_mode};
        OFF_MODE2:
          n.rdata = {24'h00_0000, r.srt, r.asr, 6'h00};
        OFF_STATUS:
          n.rdata = {13'h0000, r.err, 4'h0, r.rd_bc4, busy, r.dll_on,
            r.st == DEV_SREF, r.bank_open};
        OFF_WDATA:
          n.rdata = 32'(r.wdata);
        OFF_SRCNT:
          n.rdata = {16'h0000, r.iref_cnt};
        default:
        begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    // beat capture on both strobe edges; a queued burst joins the running one
    if (take)
    begin
      n.wdata = dq_s;
      n.wvalid = 1'b1;
    end
    n.rem = r.rem + (add ? r.lat[0] : 4'h0) - {3'h0, take};
    // one slot per ck rise of write latency, so bursts in flight never overwrite
    if (ck_rise)
    begin
      n.lat = r.lat >> 4;
      n.cke_q = cke_s;
      if (r.ccd != 2'h0)
        n.ccd = r.ccd - 2'h1;
    end
    case (r.st)
      DEV_IDLE:
        if (sre_cmd)
        begin
          n.st = DEV_SREF;
          n.dll_on = 1'b0;
          n.iref = 1'b1;
          n.iref_cnt = r.iref_cnt + 16'h0001;
          n.iref_tmr = reload;
          if (r.bank_open != 8'h00 || busy || odt_s)
            n.err[ERR_SRE] = 1'b1;
        end
        else if (cmd_go)
          case (cmd)
            CMD_ACT:
              n.bank_open[ba_s] = 1'b1;
            CMD_PRE:
              if (a10_s)
                n.bank_open = 8'h00;
              else
                n.bank_open[ba_s] = 1'b0;
            CMD_WR:
            begin
              if (!r.bank_open[ba_s])
                n.err[ERR_CLOSED] = 1'b1;
              // a write closer than the column spacing overlaps the one before
              if (r.ccd != 2'h0)
                n.err[ERR_OVR] = 1'b1;
              n.ccd = CCD_LEFT;
              n.lat[WL-1] = blen;
            end
            CMD_RD:
            begin
              if (!r.bank_open[ba_s])
                n.err[ERR_CLOSED] = 1'b1;
              n.rd_bc4 = blen == BEATS_BC4;
            end
            default:
              n.st = DEV_IDLE;
          endcase
      DEV_SREF:
        // all pins but ck, cke and hot are ignored here
        if (srx)
        begin
          n.st = DEV_IDLE;
          n.dll_on = 1'b1;
          n.dll_rst = 1'b1;
        end
        else if (r.iref_tmr == '0)
        begin
          n.iref = 1'b1;
          n.iref_cnt = r.iref_cnt + 16'h0001;
          n.iref_tmr = reload;
        end
        else
          n.iref_tmr = r.iref_tmr - 1'b1;
      default:
        n.st = DEV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.st <= DEV_IDLE;
      r.dll_on <= 1'b1;
      r.bl_mode <= MODE0_BL_RST;
      r.asr <= MODE2_ASR_RST;
      r.srt <= MODE2_SRT_RST;
    end
    else if (ce)
      r <= n;
  end

  assign wr_data = r.wdata;
  assign wr_valid = r.wvalid;
  assign in_sr = r.st == DEV_SREF;
  assign dll_on = r.dll_on;
  assign dll_rst = r.dll_rst;
  assign int_ref = r.iref;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;

  property p_concat;
    @(posedge clk) disable iff (!nrst)
    (ce && add && take && r.rem == 4'h1) |=> (r.rem == $past(r.lat[0]));
  endproperty
  a_concat: assert property (p_concat) else $error("burst join gap");

  property p_bc4_fixed;
    @(posedge clk) disable iff (!nrst)
    (ce && wr_go && r.bl_mode == BL_MODE_BC4) |=> (r.lat[WL-1] == BEATS_BC4);
  endproperty
  a_bc4_fixed: assert property (p_bc4_fixed) else $error("fixed chop");

  property p_bc4_otf;
    @(posedge clk) disable iff (!nrst)
    (ce && wr_go && r.bl_mode == BL_MODE_OTF && !a12_s) |=> (r.lat[WL-1] == BEATS_BC4);
  endproperty
  a_bc4_otf: assert property (p_bc4_otf) else $error("otf chop");

  property p_bl8;
    @(posedge clk) disable iff (!nrst)
    (ce && wr_go && (r.bl_mode == BL_MODE_8 || (r.bl_mode == BL_MODE_OTF && a12_s)))
      |=> (r.lat[WL-1] == BEATS_BL8 && r.ccd == CCD_LEFT);
  endproperty
  a_bl8: assert property (p_bl8) else $error("full burst");

  property p_pre_all;
    @(posedge clk) disable iff (!nrst)
    (ce && pre_go && a10_s) |=> (r.bank_open == 8'h00);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank close");

  property p_pre_one;
    @(posedge clk) disable iff (!nrst)
    (ce && pre_go && !a10_s) |=> (!r.bank_open[$past(ba_s)]);
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("one-bank close");

  property p_closed;
    @(posedge clk) disable iff (!nrst)
    (ce && wr_go && !r.bank_open[ba_s]) |=> r.err[ERR_CLOSED];
  endproperty
  a_closed: assert property (p_closed) else $error("closed bank access");

  sequence s_sre_cmd;
    ce && sre_cmd;
  endsequence
  sequence s_sr_held;
    r.st == DEV_SREF && !r.dll_on && r.iref;
  endsequence
  property p_sre;
    @(posedge clk) disable iff (!nrst)
    s_sre_cmd |=> s_sr_held;
  endproperty
  a_sre: assert property (p_sre) else $error("self refresh entry");

  sequence s_srx;
    ce && srx;
  endsequence
  property p_srx;
    @(posedge clk) disable iff (!nrst)
    s_srx |=> (r.st == DEV_IDLE && r.dll_on && r.dll_rst);
  endproperty
  a_srx: assert property (p_srx) else $error("self refresh exit");

  property p_sr_quiet;
    @(posedge clk) disable iff (!nrst)
    (ce && r.st == DEV_SREF && ck_rise && !cke_s) |=> ($stable(r.bank_open)
      && r.st == DEV_SREF && !r.dll_on);
  endproperty
  a_sr_quiet: assert property (p_sr_quiet) else $error("pins not ignored");

  property p_asr;
    @(posedge clk) disable iff (!nrst)
    (ce && r.st == DEV_SREF && r.asr && !srx && r.iref_tmr == '0)
      |=> (r.iref && r.iref_tmr == ($past(hot_s) ? RELOAD_EXT : RELOAD_NORM));
  endproperty
  a_asr: assert property (p_asr) else $error("auto refresh rate");
endmodule

// [verif/dwps_ctrl_model.sv]
`timescale 1ns/1ps
module dwps_ctrl_model
  import dwps_pkg::*;
#(
  parameter int DQW = 16,
  parameter int WL = WL_CK_DEF
)
(
  // memory pins
  output logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic a10,
  output logic a12,
  output logic [2:0] ba,
  output logic odt,
  // write strobe and data
  output logic dqs_t,
  output logic [DQW-1:0] dq
);
  initial
  begin
    ck = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    {a10, a12, ba} = 5'h00;
    odt = 1'b0;
    dqs_t = 1'b1;
    dq = '0;
  end

  always #62.5 ck = ~ck;

  // command set up on a falling edge, deselect on the next falling edge
  task automatic cmd(input logic [2:0] c, input logic k, input logic [4:0] adr);
    @(negedge ck);
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = c;
    cke = k;
    {a10, a12, ba} = adr;
    @(negedge ck);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    {a10, a12, ba} = ~adr;
  endtask

  // strobe high a clock ahead, half clock low, centred beats, then postamble
  task automatic burst(input int n, input logic [DQW-1:0] base);
    repeat (WL - 1) @(posedge ck);
    @(negedge ck);
    #31 dqs_t = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(ck);
      dq = base + DQW'(i);
      #31 dqs_t = ~dqs_t;
    end
    @(ck);
    dq = ~dq;
    #31 dqs_t = 1'b1;
  endtask
endmodule

// [verif/dwps_tb_top.sv]
`timescale 1ns/1ps
module dwps_tb_top
  import dwps_pkg::*;
;
  logic clk = 1'b0;
  logic nrst, hot, wr_valid, in_sr, dll_on, dll_rst, int_ref;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, a10, a12, odt, dqs_t;
  logic [2:0] ba;
  logic [15:0] dq, wr_data;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int err_count = 0, n_checks = 0, beats = 0, gap = 0, last_gap = 0, rst_pulses = 0;

  always #5 clk = ~clk;

  dwps_dev u_dwps_dev (
    .clk(clk), .nrst(nrst), .ce(1'b1), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .a10(a10), .a12(a12), .ba(ba), .odt(odt), .dqs_t(dqs_t),
    .dq(dq), .hot(hot), .wr_data(wr_data), .wr_valid(wr_valid), .in_sr(in_sr),
    .dll_on(dll_on), .dll_rst(dll_rst), .int_ref(int_ref),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  dwps_ctrl_model u_dwps_ctrl_model (
    .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .a10(a10), .a12(a12), .ba(ba), .odt(odt), .dqs_t(dqs_t), .dq(dq)
  );

  // beat count, delay loop resets, spacing of internal refreshes
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1)
      beats <= beats + 1;
    if (dll_rst === 1'b1)
      rst_pulses <= rst_pulses + 1;
    gap <= (int_ref === 1'b1) ? 1 : gap + 1;
    if (int_ref === 1'b1)
      last_gap <= gap;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d, output logic [1:0] r);
    bit done;
    bit aw_t;
    bit w_t;
    bit b_t;
    logic [1:0] rs;
    done = 1'b0;
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      // look before the edge, so the handshake seen is the one that edge takes
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      rs = bresp;
      @(posedge clk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
      begin
        r = rs;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      err_count++;
      close_out();
    end
  endtask

  task automatic axi_rd(input logic [4:0] ad, output logic [31:0] d, output logic [1:0] r);
    bit done;
    bit ar_t;
    bit r_t;
    logic [31:0] ds;
    logic [1:0] rs;
    done = 1'b0;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      ds = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
      begin
        d = ds;
        r = rs;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
    begin
      err_count++;
      close_out();
    end
  endtask

  task automatic rchk(input string what, input logic [4:0] ad, input logic [31:0] m,
                      input logic [31:0] e);
    axi_rd(ad, rd_v, rsp);
    chk(what, e, rd_v & m);
  endtask

  task automatic t_reset();
    rchk("mode0", OFF_MODE0, 32'h0000_0003, 32'(MODE0_BL_RST));
    rchk("mode2", OFF_MODE2, 32'h0000_00C0, 32'h0000_0000);
    rchk("status", OFF_STATUS, 32'h0007_03FF, 32'h0000_0200);
    axi_rd(5'h14, rd_v, rsp);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
    chk("unmapped rdata", 32'h0000_0000, rd_v);
    axi_wr(5'h18, 32'hFFFF_FFFF, rsp);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rsp));
  endtask

  task automatic t_bank();
    u_dwps_ctrl_model.cmd(CMD_WR, 1'b1, 5'h03);
    u_dwps_ctrl_model.burst(8, 16'h0000);
    rchk("closed bank", OFF_STATUS, 32'h0001_0000, 32'h0001_0000);
    axi_wr(OFF_STATUS, 32'h0007_0000, rsp);
    u_dwps_ctrl_model.cmd(CMD_ACT, 1'b1, 5'h03);
    u_dwps_ctrl_model.cmd(CMD_ACT, 1'b1, 5'h02);
    rchk("open banks", OFF_STATUS, 32'h0001_00FF, 32'h0000_000C);
    u_dwps_ctrl_model.cmd(CMD_PRE, 1'b1, 5'h03);
    rchk("one bank shut", OFF_STATUS, 32'h0000_00FF, 32'h0000_0004);
    u_dwps_ctrl_model.cmd(CMD_PRE, 1'b1, 5'h15);
    rchk("all banks shut", OFF_STATUS, 32'h0000_00FF, 32'h0000_0000);
    u_dwps_ctrl_model.cmd(CMD_WR, 1'b1, 5'h02);
    u_dwps_ctrl_model.burst(8, 16'h0000);
    rchk("shut bank write", OFF_STATUS, 32'h0001_0000, 32'h0001_0000);
    axi_wr(OFF_STATUS, 32'h0007_0000, rsp);
  endtask

  task automatic t_burst();
    logic [1:0] m [4];
    logic [3:0] n [4];
    logic [3:0] hi;
    int b0;
    m = '{BL_MODE_8, BL_MODE_BC4, BL_MODE_OTF, BL_MODE_OTF};
    n = '{BEATS_BL8, BEATS_BC4, BEATS_BC4, BEATS_BL8};
    hi = 4'b1010;
    u_dwps_ctrl_model.cmd(CMD_ACT, 1'b1, 5'h01);
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(OFF_MODE0, 32'(m[k]), rsp);
      b0 = beats;
      u_dwps_ctrl_model.cmd(CMD_WR, 1'b1, {1'b0, hi[k], 3'h1});
      // eight strobe edges even when chopped, so extra beats would show
      u_dwps_ctrl_model.burst(8, 16'(k * 256));
      repeat (8) @(posedge clk);
      chk("beats", 32'(n[k]), 32'(beats - b0));
      chk("last beat", 32'(k * 256 + n[k] - 1), 32'(wr_data));
    end
    b0 = beats;
    u_dwps_ctrl_model.cmd(CMD_WR, 1'b1, 5'h09);
    fork
      u_dwps_ctrl_model.burst(16, 16'h2000);
      begin
        repeat (2) @(negedge ck);
        u_dwps_ctrl_model.cmd(CMD_WR, 1'b1, 5'h09);
      end
    join
    repeat (8) @(posedge clk);
    chk("joined beats", 32'd16, 32'(beats - b0));
    chk("joined last", 32'h0000_200F, 32'(wr_data));
    // read only after the write-to-read delay from the last beat has run
    repeat (4) @(posedge ck);
    u_dwps_ctrl_model.cmd(CMD_RD, 1'b1, 5'h01);
    rchk("read chop", OFF_STATUS, 32'h0001_0800, 32'h0000_0800);
  endtask

  task automatic t_sr(input logic [31:0] m2, input logic h, input int g);
    logic [31:0] c0;
    int r0;
    axi_wr(OFF_MODE2, m2, rsp);
    hot <= h;
    u_dwps_ctrl_model.cmd(CMD_PRE, 1'b1, 5'h10);
    axi_rd(OFF_SRCNT, c0, rsp);
    r0 = rst_pulses;
    u_dwps_ctrl_model.cmd(CMD_REF, 1'b0, 5'h00);
    repeat (4) @(posedge clk);
    chk("in self refresh", 32'd1, 32'(in_sr));
    chk("loop off", 32'd0, 32'(dll_on));
    rchk("refresh count", OFF_SRCNT, 32'h0000_FFFF, (c0 + 1) & 32'h0000_FFFF);
    repeat (1700) @(posedge clk);
    chk("refresh gap", 32'(g), 32'(last_gap));
    u_dwps_ctrl_model.cmd(3'h7, 1'b1, 5'h00);
    repeat (4) @(posedge clk);
    chk("left self refresh", 32'd0, 32'(in_sr));
    chk("loop on", 32'd1, 32'(dll_on));
    chk("loop reset", 32'd1, 32'(rst_pulses - r0));
    repeat (8) @(posedge ck);
  endtask

  initial
  begin
    nrst = 1'b0;
    hot = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 10'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ck);
    t_reset();
    t_bank();
    t_burst();
    t_sr(32'h0000_0000, 1'b0, TREFI_NORM_CYC);
    t_sr(32'h0000_0080, 1'b0, TREFI_EXT_CYC);
    t_sr(32'h0000_0040, 1'b1, TREFI_EXT_CYC);
    close_out();
  end
endmodule
